//--- rtl/phy_special_modes_control.sv
// special modes register of one integrated phy: fiber mode, operating mode and management address
// What this block does
// - the phy runs in fiber mode whenever the fiber mode enable bit is set; speed_100_o still follows only the mode field.
// - the phy operating mode is taken from the three-bit mode field in bits 7 down to 5 of the register.
// - the phy answers management transactions only when their phy address equals the management address field.
// - the management address field seeds the transmit scrambler key.
// - mode codes decode as 10M half, 10M full, 100M half, 100M full, autoneg 100M full, reserved, power down, all.
// - after reset the mode defaults to 0, 1, duplex strap with the fiber strap, else to 111b with the autoneg strap, else to 0, speed strap, duplex strap.
// - a phy reset from the reset control register reloads all three fields when soft reset applies.
`include "special_modes_map.svh"

module phy_special_modes_control (
  input wire logic clock_i,
  input wire logic reset_n_i,
  // configuration straps, asynchronous pins
  input wire logic fiber_strap_i,
  input wire logic autoneg_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic [`ADDRESS_WIDTH-1:0] address_strap_i,
  // decoded management frame from the management interface logic
  input wire logic [`ADDRESS_WIDTH-1:0] frame_phy_address_i,
  input wire logic [`REG_INDEX_WIDTH-1:0] frame_reg_index_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic [`REG_DATA_WIDTH-1:0] write_data_i,
  // phy reset from the reset control register, and the soft reset enable bit
  input wire logic reset_control_phy_reset_i,
  input wire logic soft_reset_clearable_i,
  output logic address_match_o,
  output logic read_valid_o,
  output logic [`REG_DATA_WIDTH-1:0] read_data_o,
  output logic [`REG_DATA_WIDTH-1:0] special_modes_register_o,
  output logic fiber_mode_enable_o,
  output special_modes_pkg::mode_t operating_mode_o,
  output special_modes_pkg::address_t management_address_o,
  output special_modes_pkg::address_t scrambler_seed_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_enable_o,
  output logic advertise_all_o,
  output logic power_down_o,
  output logic mode_reserved_o,
  output logic defaults_loaded_o
);

  special_modes_pkg::strap_state_t strap_state;
  special_modes_pkg::strap_state_t next_strap_state;
  logic [`SETTLE_COUNT_WIDTH-1:0] settle_count;

  logic default_fiber_mode;
  special_modes_pkg::mode_t default_mode;
  special_modes_pkg::address_t default_address;

  logic fiber_mode_enable;
  special_modes_pkg::mode_t operating_mode;
  special_modes_pkg::address_t management_address;

  logic address_hit;
  logic register_hit;
  logic reload_defaults;
  logic register_write;
  logic [`REG_DATA_WIDTH-1:0] register_image;
  logic [`REG_DATA_WIDTH-1:0] masked_write;

  strap_capture u_strap_capture (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .fiber_strap_i(fiber_strap_i),
    .autoneg_strap_i(autoneg_strap_i),
    .speed_strap_i(speed_strap_i),
    .duplex_strap_i(duplex_strap_i),
    .address_strap_i(address_strap_i),
    .default_fiber_mode_o(default_fiber_mode),
    .default_mode_o(default_mode),
    .default_address_o(default_address)
  );

  // straps are caught after reset release, once the synchroniser has filled
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_count <= '0;
    end else if (strap_state == special_modes_pkg::STRAP_WAIT) begin
      settle_count <= settle_count + `SETTLE_COUNT_WIDTH'(1);
    end
  end

  always_comb begin
    case (strap_state)
      special_modes_pkg::STRAP_WAIT: begin
        if (settle_count == `STRAP_SETTLE_CYCLES - `SETTLE_COUNT_WIDTH'(1)) begin
          next_strap_state = special_modes_pkg::STRAP_LOAD;
        end else begin
          next_strap_state = special_modes_pkg::STRAP_WAIT;
        end
      end
      special_modes_pkg::STRAP_LOAD: begin
        next_strap_state = special_modes_pkg::STRAP_RUN;
      end
      special_modes_pkg::STRAP_RUN: begin
        next_strap_state = special_modes_pkg::STRAP_RUN;
      end
      default: begin
        next_strap_state = special_modes_pkg::STRAP_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_state <= special_modes_pkg::STRAP_WAIT;
    end else begin
      strap_state <= next_strap_state;
    end
  end

  assign address_hit = (frame_phy_address_i == management_address);
  assign register_hit = address_hit && (frame_reg_index_i == `SPECIAL_MODES_INDEX);

  assign reload_defaults = (strap_state == special_modes_pkg::STRAP_LOAD)
                           || (reset_control_phy_reset_i && soft_reset_clearable_i);

  // writes before the straps are caught would be overwritten by the load anyway
  assign register_write = write_strobe_i && register_hit && (strap_state == special_modes_pkg::STRAP_RUN);

  assign masked_write = write_data_i & `WRITABLE_MASK;

  // strap defaults loaded
  // the reload beats a write in the same cycle, as a reset should
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fiber_mode_enable <= `FIBER_MODE_RESET;
    end else if (reload_defaults) begin
      fiber_mode_enable <= default_fiber_mode;
    end else if (register_write) begin
      fiber_mode_enable <= masked_write[`FIBER_MODE_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      operating_mode <= `MODE_RESET;
    end else if (reload_defaults) begin
      operating_mode <= default_mode;
    end else if (register_write) begin
      operating_mode <= masked_write[`MODE_MSB:`MODE_LSB];
    end
  end

  // no uniqueness check against the other phys; software owns that
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      management_address <= `ADDRESS_RESET;
    end else if (reload_defaults) begin
      management_address <= default_address;
    end else if (register_write) begin
      management_address <= masked_write[`ADDRESS_MSB:`ADDRESS_LSB];
    end
  end

  always_comb begin
    register_image = '0;
    register_image[`FIBER_MODE_BIT] = fiber_mode_enable;
    register_image[`MODE_MSB:`MODE_LSB] = operating_mode;
    register_image[`ADDRESS_MSB:`ADDRESS_LSB] = management_address;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      read_valid_o <= 1'h0;
      read_data_o <= '0;
      address_match_o <= 1'h0;
    end else begin
      read_valid_o <= read_strobe_i && register_hit;
      address_match_o <= (read_strobe_i || write_strobe_i) && address_hit;
      if (read_strobe_i && register_hit) begin
        read_data_o <= register_image;
      end
    end
  end

  assign special_modes_register_o = register_image;
  assign defaults_loaded_o = (strap_state == special_modes_pkg::STRAP_RUN);

  assign fiber_mode_enable_o = fiber_mode_enable;
  assign operating_mode_o = operating_mode;
  assign management_address_o = management_address;

  assign scrambler_seed_o = management_address;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_100_o <= 1'h0;
      full_duplex_o <= 1'h0;
      autoneg_enable_o <= 1'h0;
      advertise_all_o <= 1'h0;
      power_down_o <= 1'h0;
      mode_reserved_o <= 1'h0;
    end else begin
      case (operating_mode)
        `MODE_10_HALF: begin
          speed_100_o <= 1'h0;
          full_duplex_o <= 1'h0;
          autoneg_enable_o <= 1'h0;
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h0;
        end
        `MODE_10_FULL: begin
          speed_100_o <= 1'h0;
          full_duplex_o <= 1'h1;
          autoneg_enable_o <= 1'h0;
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h0;
        end
        `MODE_100_HALF: begin
          speed_100_o <= 1'h1;
          full_duplex_o <= 1'h0;
          autoneg_enable_o <= 1'h0;
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h0;
        end
        `MODE_100_FULL, `MODE_AN_100_FULL: begin
          speed_100_o <= 1'h1;
          full_duplex_o <= 1'h1;
          autoneg_enable_o <= (operating_mode == `MODE_AN_100_FULL);
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h0;
        end
        `MODE_POWER_DOWN: begin
          speed_100_o <= 1'h0;
          full_duplex_o <= 1'h0;
          autoneg_enable_o <= 1'h0;
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h1;
          mode_reserved_o <= 1'h0;
        end
        `MODE_ALL_CAPABLE: begin
          speed_100_o <= 1'h1;
          full_duplex_o <= 1'h1;
          autoneg_enable_o <= 1'h1;
          advertise_all_o <= 1'h1;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h0;
        end
        // reserved code: flagged, link settings held at the safest idle values
        default: begin
          speed_100_o <= 1'h0;
          full_duplex_o <= 1'h0;
          autoneg_enable_o <= 1'h0;
          advertise_all_o <= 1'h0;
          power_down_o <= 1'h0;
          mode_reserved_o <= 1'h1;
        end
      endcase
    end
  end

endmodule : phy_special_modes_control

//--- rtl/special_modes_map.svh
// register index, field layout, reset values and timing counts of the special modes register
`ifndef SPECIAL_MODES_MAP_SVH
`define SPECIAL_MODES_MAP_SVH

// register index within the management register space of one phy
`define SPECIAL_MODES_INDEX 5'h12
`define REG_INDEX_WIDTH 5
`define REG_DATA_WIDTH 16

// field positions
`define FIBER_MODE_BIT 10
`define MODE_MSB 7
`define MODE_LSB 5
`define MODE_WIDTH 3
`define ADDRESS_MSB 4
`define ADDRESS_LSB 0
`define ADDRESS_WIDTH 5

// writable bits; everything else reads zero
`define WRITABLE_MASK 16'h04FF

// values held between asynchronous reset and strap capture
`define FIBER_MODE_RESET 1'h0
`define MODE_RESET 3'h0
`define ADDRESS_RESET 5'h00

// operating mode encodings
`define MODE_10_HALF 3'h0
`define MODE_10_FULL 3'h1
`define MODE_100_HALF 3'h2
`define MODE_100_FULL 3'h3
`define MODE_AN_100_FULL 3'h4
`define MODE_RESERVED 3'h5
`define MODE_POWER_DOWN 3'h6
`define MODE_ALL_CAPABLE 3'h7

// strap default with auto-negotiation strapped on
`define MODE_AUTONEG_DEFAULT 3'h7

// cycles from reset release until synchronised straps are stable in the capture register
`define STRAP_SETTLE_CYCLES 2'h3
`define SETTLE_COUNT_WIDTH 2

`endif

//--- rtl/special_modes_pkg.sv
// types shared by the special modes register files
package special_modes_pkg;

  // gray-coded along wait -> load -> run
  typedef enum logic [1:0] {
    STRAP_WAIT = 2'h0,
    STRAP_LOAD = 2'h1,
    STRAP_RUN = 2'h3
  } strap_state_t;

  typedef logic [2:0] mode_t;
  typedef logic [4:0] address_t;

endpackage : special_modes_pkg

//--- rtl/strap_capture.sv
// strap synchroniser and default value builder for the special modes register
`include "special_modes_map.svh"

module strap_capture (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic fiber_strap_i,
  input wire logic autoneg_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic [`ADDRESS_WIDTH-1:0] address_strap_i,
  output logic default_fiber_mode_o,
  output special_modes_pkg::mode_t default_mode_o,
  output special_modes_pkg::address_t default_address_o
);

  localparam int STRAP_WIDTH = 4 + `ADDRESS_WIDTH;

  logic [STRAP_WIDTH-1:0] strap_meta;
  logic [STRAP_WIDTH-1:0] strap_sync;
  logic fiber;
  logic autoneg;
  logic speed;
  logic duplex;
  special_modes_pkg::mode_t next_mode;

  // straps are pins; only the second stage is looked at
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= {fiber_strap_i, autoneg_strap_i, speed_strap_i, duplex_strap_i, address_strap_i};
      strap_sync <= strap_meta;
    end
  end

  assign fiber = strap_sync[STRAP_WIDTH-1];
  assign autoneg = strap_sync[STRAP_WIDTH-2];
  assign speed = strap_sync[STRAP_WIDTH-3];
  assign duplex = strap_sync[STRAP_WIDTH-4];

  // fiber forces 100 without negotiation; otherwise autoneg strap wins over speed and duplex
  always_comb begin
    if (fiber) begin
      next_mode = {1'h0, 1'h1, duplex};
    end else if (autoneg) begin
      next_mode = `MODE_AUTONEG_DEFAULT;
    end else begin
      next_mode = {1'h0, speed, duplex};
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      default_fiber_mode_o <= `FIBER_MODE_RESET;
      default_mode_o <= `MODE_RESET;
      default_address_o <= `ADDRESS_RESET;
    end else begin
      default_fiber_mode_o <= fiber;
      default_mode_o <= next_mode;
      default_address_o <= strap_sync[`ADDRESS_WIDTH-1:0];
    end
  end

endmodule : strap_capture

//--- bench/phy_special_modes_control_sva.sv
// port checker for the special modes register
`include "special_modes_map.svh"
module phy_special_modes_control_sva (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [4:0] frame_phy_address_i,
  input wire logic [4:0] frame_reg_index_i,
  input wire logic read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic [15:0] write_data_i,
  input wire logic reset_control_phy_reset_i,
  input wire logic soft_reset_clearable_i,
  input wire logic address_match_o,
  input wire logic read_valid_o,
  input wire logic [15:0] read_data_o,
  input wire logic [15:0] special_modes_register_o,
  input wire logic fiber_mode_enable_o,
  input wire special_modes_pkg::mode_t operating_mode_o,
  input wire special_modes_pkg::address_t management_address_o,
  input wire special_modes_pkg::address_t scrambler_seed_o,
  input wire logic advertise_all_o,
  input wire logic power_down_o,
  input wire logic mode_reserved_o,
  input wire logic defaults_loaded_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic hit = frame_phy_address_i == management_address_o && frame_reg_index_i == `SPECIAL_MODES_INDEX;
  wire logic reload = reset_control_phy_reset_i && soft_reset_clearable_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  AST_SEED: assert property (scrambler_seed_o == management_address_o)
    else $error("seed differs from address");
  AST_RSVD: assert property ((special_modes_register_o & ~`WRITABLE_MASK) == 16'h0000)
    else $error("reserved bit set");
  AST_IMAGE: assert property (special_modes_register_o[10] == fiber_mode_enable_o
    && special_modes_register_o[7:5] == operating_mode_o) else $error("image and fields disagree");
  AST_READ: assert property (read_strobe_i && hit |=> read_valid_o && read_data_o == $past(special_modes_register_o))
    else $error("read answer wrong");
  // the strap load may change the image on its own, so only watch once loaded
  AST_MISS: assert property (defaults_loaded_o && (read_strobe_i || write_strobe_i) && !reset_control_phy_reset_i
    && frame_phy_address_i != management_address_o |=> !address_match_o && !read_valid_o
    && $stable(special_modes_register_o)) else $error("answered foreign address");
  AST_WRITE: assert property (defaults_loaded_o && write_strobe_i && hit && !reload
    |=> special_modes_register_o == ($past(write_data_i) & `WRITABLE_MASK)) else $error("write not stored");
  AST_NORELOAD: assert property (defaults_loaded_o && reset_control_phy_reset_i && !soft_reset_clearable_i
    && !write_strobe_i |=> $stable(special_modes_register_o)) else $error("reload without soft reset");
  AST_DECODE: assert property ({power_down_o, mode_reserved_o, advertise_all_o} == {$past(operating_mode_o) == 3'h6,
    $past(operating_mode_o) == 3'h5, $past(operating_mode_o) == 3'h7}) else $error("mode decode wrong");
  COV_READ: cover property (read_valid_o);
  COV_PDN: cover property (power_down_o);
  COV_RELOAD: cover property (defaults_loaded_o && reload);
endmodule : phy_special_modes_control_sva

bind phy_special_modes_control phy_special_modes_control_sva phy_special_modes_control_sva_inst (
  .clock_i(clock_i),
  .reset_n_i(reset_n_i),
  .frame_phy_address_i(frame_phy_address_i),
  .frame_reg_index_i(frame_reg_index_i),
  .read_strobe_i(read_strobe_i),
  .write_strobe_i(write_strobe_i),
  .write_data_i(write_data_i),
  .reset_control_phy_reset_i(reset_control_phy_reset_i),
  .soft_reset_clearable_i(soft_reset_clearable_i),
  .address_match_o(address_match_o),
  .read_valid_o(read_valid_o),
  .read_data_o(read_data_o),
  .special_modes_register_o(special_modes_register_o),
  .fiber_mode_enable_o(fiber_mode_enable_o),
  .operating_mode_o(operating_mode_o),
  .management_address_o(management_address_o),
  .scrambler_seed_o(scrambler_seed_o),
  .advertise_all_o(advertise_all_o),
  .power_down_o(power_down_o),
  .mode_reserved_o(mode_reserved_o),
  .defaults_loaded_o(defaults_loaded_o)
);

//--- bench/mgmt_station.sv
// management station model issuing decoded frames
module mgmt_station (
  input wire logic clock_i,
  input wire logic read_valid_i,
  input wire logic address_match_i,
  input wire logic [15:0] read_data_i,
  output logic [4:0] phy_address_o,
  output logic [4:0] reg_index_o,
  output logic read_strobe_o,
  output logic write_strobe_o,
  output logic [15:0] write_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {phy_address_o, reg_index_o, read_strobe_o, write_strobe_o, write_data_o} = 28'h0000000;
  task access(input logic w, input logic [4:0] a, input logic [15:0] d,
    output logic v, output logic m, output logic [15:0] q);
    @(negedge clock_i);
    {phy_address_o, reg_index_o, write_data_o} = {a, 5'h12, d};
    {read_strobe_o, write_strobe_o} = {!w, w};
    @(negedge clock_i);
    {v, m, q} = {read_valid_i, address_match_i, read_data_i};
    // idle lines flip so a stale frame can never look live
    {phy_address_o, reg_index_o, write_data_o} = ~{a, 5'h12, d};
    {read_strobe_o, write_strobe_o} = 2'h0;
  endtask : access
  task update(input logic [4:0] a, input logic [15:0] mask, input logic [15:0] val);
    logic v, m;
    logic [15:0] q;
    access(1'b0, a, 16'h0000, v, m, q);
    access(1'b1, a, (q & ~mask) | (val & mask), v, m, q);
  endtask : update
endmodule : mgmt_station

//--- bench/phy_special_modes_control_bench.sv
// self-checking bench for the special modes register
module phy_special_modes_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0, reset_n_i = 1'b0, fiber_strap_i = 1'b0, autoneg_strap_i = 1'b0;
  logic speed_strap_i = 1'b0, duplex_strap_i = 1'b0, reset_control_phy_reset_i = 1'b0, soft_reset_clearable_i = 1'b0;
  logic [4:0] address_strap_i = 5'h00, frame_phy_address_i, frame_reg_index_i;
  logic read_strobe_i, write_strobe_i, address_match_o, read_valid_o, fiber_mode_enable_o, speed_100_o;
  logic full_duplex_o, autoneg_enable_o, advertise_all_o, power_down_o, mode_reserved_o, defaults_loaded_o;
  logic [15:0] write_data_i, read_data_o, special_modes_register_o, exp_img;
  special_modes_pkg::mode_t operating_mode_o;
  special_modes_pkg::address_t management_address_o, scrambler_seed_o;
  logic [5:0] dec_tab [8] = '{6'h00, 6'h10, 6'h20, 6'h30, 6'h38, 6'h01, 6'h02, 6'h3C};
  int miscompares = 0, checks = 0, cycles = 0;
  always #12.5 clock_i = ~clock_i;
  phy_special_modes_control phy_special_modes_control_inst (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .fiber_strap_i(fiber_strap_i),
    .autoneg_strap_i(autoneg_strap_i),
    .speed_strap_i(speed_strap_i),
    .duplex_strap_i(duplex_strap_i),
    .address_strap_i(address_strap_i),
    .frame_phy_address_i(frame_phy_address_i),
    .frame_reg_index_i(frame_reg_index_i),
    .read_strobe_i(read_strobe_i),
    .write_strobe_i(write_strobe_i),
    .write_data_i(write_data_i),
    .reset_control_phy_reset_i(reset_control_phy_reset_i),
    .soft_reset_clearable_i(soft_reset_clearable_i),
    .address_match_o(address_match_o),
    .read_valid_o(read_valid_o),
    .read_data_o(read_data_o),
    .special_modes_register_o(special_modes_register_o),
    .fiber_mode_enable_o(fiber_mode_enable_o),
    .operating_mode_o(operating_mode_o),
    .management_address_o(management_address_o),
    .scrambler_seed_o(scrambler_seed_o),
    .speed_100_o(speed_100_o),
    .full_duplex_o(full_duplex_o),
    .autoneg_enable_o(autoneg_enable_o),
    .advertise_all_o(advertise_all_o),
    .power_down_o(power_down_o),
    .mode_reserved_o(mode_reserved_o),
    .defaults_loaded_o(defaults_loaded_o)
  );
  mgmt_station mgmt_station_inst (.clock_i(clock_i), .read_valid_i(read_valid_o), .address_match_i(address_match_o),
    .read_data_i(read_data_o), .phy_address_o(frame_phy_address_i), .reg_index_o(frame_reg_index_i),
    .read_strobe_o(read_strobe_i), .write_strobe_o(write_strobe_i), .write_data_o(write_data_i));
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task close_out;
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  function automatic logic [15:0] dflt;
    logic [2:0] m;
    m = fiber_strap_i ? {2'h1, duplex_strap_i} : autoneg_strap_i ? 3'h7 : {1'b0, speed_strap_i, duplex_strap_i};
    return {5'h00, fiber_strap_i, 2'h0, m, address_strap_i};
  endfunction : dflt
  task rd(input logic [4:0] a, input logic hit);
    logic v, m;
    logic [15:0] q;
    mgmt_station_inst.access(1'b0, a, 16'h0000, v, m, q);
    chk("read_valid", {15'h0000, v}, {15'h0000, hit});
    chk("address_match", {15'h0000, m}, {15'h0000, hit});
    if (hit) chk("read_data", q, exp_img);
    chk("image", special_modes_register_o, exp_img);
    chk("fiber_mode", {15'h0000, fiber_mode_enable_o}, {15'h0000, exp_img[10]});
    chk("mode", {13'h0000, operating_mode_o}, {13'h0000, exp_img[7:5]});
    chk("address", {11'h000, management_address_o}, {11'h000, exp_img[4:0]});
    chk("seed", {11'h000, scrambler_seed_o}, {11'h000, exp_img[4:0]});
  endtask : rd
  task set(input logic [15:0] mask, input logic [15:0] val);
    mgmt_station_inst.update(exp_img[4:0], mask, val);
    exp_img = ((exp_img & ~mask) | (val & mask)) & 16'h04FF;
    rd(exp_img[4:0], 1'b1);
    chk("decode", {10'h000, speed_100_o, full_duplex_o, autoneg_enable_o, advertise_all_o, power_down_o,
      mode_reserved_o}, {10'h000, dec_tab[exp_img[7:5]]});
  endtask : set
  task pulse(input logic c);
    @(negedge clock_i);
    {reset_control_phy_reset_i, soft_reset_clearable_i} = {1'b1, c};
    @(negedge clock_i);
    reset_control_phy_reset_i = 1'b0;
  endtask : pulse
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    int n;
    void'($urandom(32'hBA1DFEA2));
    for (int i = 0; i < 4; i++) begin
      @(negedge clock_i);
      reset_n_i = 1'b0;
      {fiber_strap_i, autoneg_strap_i} = 2'(i);
      {speed_strap_i, duplex_strap_i, address_strap_i} = 7'($urandom);
      repeat (20) @(negedge clock_i);
      reset_n_i = 1'b1;
      n = 0;
      while (defaults_loaded_o !== 1'b1 && n < 10) begin
        @(negedge clock_i);
        n++;
      end
      chk("defaults_loaded", {15'h0000, defaults_loaded_o}, 16'h0001);
      exp_img = dflt();
      set(16'h0000, 16'h0000);
      rd(exp_img[4:0] ^ 5'h01, 1'b0);
      mgmt_station_inst.update(exp_img[4:0] ^ 5'h01, 16'h00E0, 16'h00A0);
      rd(exp_img[4:0], 1'b1);
      for (int m = 0; m < 8; m++) set(16'h00E0, {8'h00, 3'(m), 5'h00});
      set(16'hFB00, 16'hFB00);
      set(16'h001F, {11'h000, 5'($urandom)});
      pulse(1'b0);
      rd(exp_img[4:0], 1'b1);
      pulse(1'b1);
      exp_img = dflt();
      rd(exp_img[4:0], 1'b1);
    end
    close_out();
  end
endmodule : phy_special_modes_control_bench
